// >>> hw/flash_array.sv
// 2K x 14 program flash model with four-word buffer and timed erase/program
`timescale 1ns/100ps
`default_nettype none
module flash_array
  import flash_self_pkg::*;
#(
  parameter int ERASE_WRITE_CYC = ERASE_WRITE_CYCLES
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire flash_self_pkg::flash_req_s req,
  output logic [flash_self_pkg::WORD_W-1:0] rd_data,
  output logic                     busy,
  output logic                     done
);
  logic [WORD_W-1:0] mem [FLASH_WORDS];  // array cells, no reset like real flash
  logic [WORD_W-1:0] buffer [4];         // four-word write latch
  logic [16:0]       timer;              // erase/program duration
  logic [FLASH_AW-1:0] block_addr;       // block being committed
  wire               row_start = (req.addr[3:2] == 2'b00); // first block of the row

  // ****************************************************************
  // control: busy timer and done pulse
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy       <= 1'b0;
      done       <= 1'b0;
      timer      <= '0;
      block_addr <= '0;
      rd_data    <= '0;
    end else begin
      done <= 1'b0;
      if (req.rd) begin
        rd_data <= mem[req.addr];
      end
      if (req.commit && !busy) begin
        busy       <= 1'b1;
        timer      <= 17'(ERASE_WRITE_CYC - 1);
        block_addr <= req.addr;
      end else if (busy) begin
        if (timer == '0) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          timer <= timer - 17'd1;
        end
      end
    end
  end

  // ****************************************************************
  // storage: buffer load, row erase at commit of a row's first block, program at timer end
  // ****************************************************************
  always_ff @(posedge pclk) begin
    if (req.load) begin
      buffer[req.addr[1:0]] <= req.data;
    end
    if (req.commit && !busy && row_start) begin
      for (int i = 0; i < 16; i++) begin
        mem[{req.addr[10:4], 4'(i)}] <= ERASED_WORD;
      end
    end
    if (busy && timer == '0) begin
      for (int i = 0; i < 4; i++) begin
        mem[{block_addr[10:2], 2'(i)}] <= buffer[i];
      end
    end
  end
endmodule : flash_array
`default_nettype wire

// >>> hw/flash_self_pkg.sv
// shared constants, types and register map of the program flash self-access block
package flash_self_pkg;

  // ****************************************************************
  // register map: printed 0x93 is not word aligned, so offsets are indices
  // ****************************************************************
  localparam logic [7:0] IDX_ACCESS_CONTROL = 8'h93; // control register index
  localparam logic [7:0] IDX_WORD_LOW       = 8'h94; // data bits 7..0
  localparam logic [7:0] IDX_WORD_HIGH      = 8'h95; // data bits 13..8
  localparam logic [7:0] IDX_ADDR_LOW       = 8'h96; // address bits 7..0
  localparam logic [7:0] IDX_ADDR_HIGH      = 8'h97; // address bits 10..8
  localparam logic [7:0] IDX_UNLOCK_KEY     = 8'h98; // write-only key port

  // ****************************************************************
  // control register fields
  // ****************************************************************
  localparam int         BIT_READ_TRIGGER   = 0;
  localparam int         BIT_WRITE_TRIGGER  = 1;
  localparam int         BIT_PROGRAM_PERMIT = 2;
  localparam logic [7:0] CONTROL_FIXED_ONES = 8'h80; // bit 7 reads one
  localparam int         WORD_HIGH_BITS     = 6;
  localparam int         ADDR_HIGH_BITS     = 3;

  // ****************************************************************
  // sizes, keys, reset values
  // ****************************************************************
  localparam int          FLASH_WORDS   = 2048;
  localparam int          FLASH_AW      = 11;
  localparam int          WORD_W        = 14;
  localparam logic [13:0] ERASED_WORD   = 14'h3FFF;
  localparam logic [7:0]  KEY_FIRST     = 8'h55;
  localparam logic [7:0]  KEY_SECOND    = 8'hAA;
  localparam logic [7:0]  RESET_BYTE    = 8'h00;
  localparam logic [1:0]  LAST_IN_BLOCK = 2'b11;
  localparam logic [10:0] LOCK_LIMIT_10 = 11'h100; // lock select 10: words below locked
  localparam logic [10:0] LOCK_LIMIT_01 = 11'h400; // lock select 01: words below locked

  // ****************************************************************
  // timing: times in their own unit, cycles derived from the clock
  // ****************************************************************
  localparam int CLK_MHZ            = 20;
  localparam int ERASE_WRITE_US     = 4000;
  localparam int POWERUP_US         = 64000;
  localparam int ERASE_WRITE_CYCLES = ERASE_WRITE_US * CLK_MHZ;
  localparam int POWERUP_CYCLES     = POWERUP_US * CLK_MHZ;
  localparam int READ_DELAY_CYCLES  = 2; // read happens in second cycle after trigger
  localparam int WRITE_SETUP_CYCLES = 2; // buffer-load setup cycles

  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_READ_WAIT, ST_READ_FETCH, ST_READ_CAPTURE, ST_WRITE_SETUP, ST_WRITE_COMMIT
  } seq_state_e;

  // request from the sequencer to the flash array
  typedef struct packed {
    logic                rd;     // one-cycle read strobe
    logic                load;   // load one buffer word
    logic                commit; // erase (if row start) and program the block
    logic [FLASH_AW-1:0] addr;   // word address
    logic [WORD_W-1:0]   data;   // word to buffer
  } flash_req_s;

endpackage : flash_self_pkg

// >>> hw/pin_sync3.sv
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module pin_sync3 #(
  parameter int         W        = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level
);
  logic [W-1:0] stage1; // read only by stage2
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  // ****************************************************************
  // capture chain; output follows only settled values
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= RST_VAL;
      stage2 <= RST_VAL;
      stage3 <= RST_VAL;
      level  <= RST_VAL;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3) begin
        level <= stage3; // agreement filters a one-cycle glitch
      end
    end
  end
endmodule : pin_sync3
`default_nettype wire

// >>> hw/program_flash_self_access.sv
// APB register front end and sequencer for program flash self read and block write
//
// The APB register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module program_flash_self_access
  import flash_self_pkg::*;
#(
  parameter int POWERUP_CYC     = POWERUP_CYCLES,
  parameter int ERASE_WRITE_CYC = ERASE_WRITE_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic [1:0]  block_lock_select,
  input  wire logic        code_lock,
  input  wire logic        serial_programming_port_req,
  output logic             serial_programming_port_grant,
  output logic             suppress_instruction,
  output logic             core_stall
);
  import flash_self_pkg::*;

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [7:0]              word_low;        // data bits 7..0
  logic [WORD_HIGH_BITS-1:0] word_high;     // data bits 13..8
  logic [7:0]              addr_low;        // address bits 7..0
  logic [ADDR_HIGH_BITS-1:0] addr_high;     // address bits 10..8
  logic                    program_permit_bit;
  logic                    read_trigger;
  logic                    write_trigger;
  logic [1:0]              key_stage;       // 0 none, 1 first key seen, 2 armed
  seq_state_e              state;
  seq_state_e              next_state;
  logic [1:0]              seq_count;       // delay inside write setup
  logic [20:0]             powerup_count;   // counts down after reset
  logic                    powerup_done;
  logic [1:0]              lock_sel;        // settled lock select pins
  logic                    lock_code;       // settled code lock pin
  logic                    serial_req;      // settled programmer request
  logic [WORD_W-1:0]       flash_rd_data;
  logic                    flash_busy;
  logic                    flash_done;
  flash_req_s              freq;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // the 2-bit lock select covers a growing region from word zero
  function automatic logic block_locked(input logic [1:0] sel, input logic [FLASH_AW-1:0] a);
    case (sel)
      2'b11:   block_locked = 1'b0;
      2'b10:   block_locked = (a < LOCK_LIMIT_10);
      2'b01:   block_locked = (a < LOCK_LIMIT_01);
      default: block_locked = 1'b1;
    endcase
  endfunction : block_locked

  // ****************************************************************
  // pin synchronisers for configuration and programmer request
  // ****************************************************************
  pin_sync3 #(.W(2), .RST_VAL(2'b00)) u_sync_lock (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (block_lock_select),
    .level   (lock_sel)
  );
  pin_sync3 #(.W(2), .RST_VAL(2'b10)) u_sync_misc (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     ({code_lock, serial_programming_port_req}),
    .level   ({lock_code, serial_req})
  );

  // ****************************************************************
  // APB decode
  // ****************************************************************
  wire              setup_phase = psel && !penable;
  wire              access      = psel && penable;
  wire [9:0]        word_index  = paddr[11:2];
  wire              in_map      = (paddr[1:0] == 2'b00) && (word_index[9:8] == 2'b00)
                                  && (word_index[7:0] >= IDX_ACCESS_CONTROL)
                                  && (word_index[7:0] <= IDX_UNLOCK_KEY);
  wire              wr_access   = access && pwrite && in_map && pstrb[0];
  wire [7:0]        wbyte       = pwdata[7:0];
  wire              wr_control  = wr_access && (word_index[7:0] == IDX_ACCESS_CONTROL);
  wire              wr_key      = wr_access && (word_index[7:0] == IDX_UNLOCK_KEY);
  wire              wr_wlow     = wr_access && (word_index[7:0] == IDX_WORD_LOW);
  wire              wr_whigh    = wr_access && (word_index[7:0] == IDX_WORD_HIGH);
  wire              wr_alow     = wr_access && (word_index[7:0] == IDX_ADDR_LOW);
  wire              wr_ahigh    = wr_access && (word_index[7:0] == IDX_ADDR_HIGH);

  // ****************************************************************
  // trigger qualification
  // ****************************************************************
  wire [FLASH_AW-1:0] flash_addr  = {addr_high, addr_low};
  wire                seq_idle    = (state == ST_IDLE);
  wire                start_read  = wr_control && wbyte[BIT_READ_TRIGGER] && seq_idle;
  wire                write_ok    = program_permit_bit && (key_stage == 2'd2)
                                    && powerup_done && !block_locked(lock_sel, flash_addr);
  wire                start_write = wr_control && wbyte[BIT_WRITE_TRIGGER] && seq_idle
                                    && !wbyte[BIT_READ_TRIGGER] && write_ok;
  wire                last_word   = (addr_low[1:0] == LAST_IN_BLOCK);

  // ****************************************************************
  // sequencer next state
  // ****************************************************************
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_read) begin
          next_state = ST_READ_WAIT;
        end else if (start_write) begin
          next_state = ST_WRITE_SETUP;
        end
      end
      ST_READ_WAIT: begin
        // first instruction after the trigger runs normally
        next_state = ST_READ_FETCH;
      end
      ST_READ_FETCH: begin
        next_state = ST_READ_CAPTURE;
      end
      ST_READ_CAPTURE: begin
        next_state = ST_IDLE;
      end
      ST_WRITE_SETUP: begin
        if (seq_count == 2'(WRITE_SETUP_CYCLES - 1)) begin
          next_state = last_word ? ST_WRITE_COMMIT : ST_IDLE;
        end
      end
      ST_WRITE_COMMIT: begin
        if (flash_done) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // flash request: loads on last setup cycle, commit right after for a block's last word
  // ****************************************************************
  wire setup_end = (state == ST_WRITE_SETUP) && (seq_count == 2'(WRITE_SETUP_CYCLES - 1));
  always_comb begin
    freq        = '0;
    freq.addr   = flash_addr;
    freq.data   = {word_high, word_low};
    freq.rd     = (state == ST_READ_FETCH);
    freq.load   = setup_end;
    freq.commit = (state == ST_WRITE_COMMIT) && !flash_busy && !flash_done;
  end

  // only the second instruction after the trigger is dropped by the core
  assign suppress_instruction = (state == ST_READ_FETCH);
  // the core halts for the whole timed erase/program
  assign core_stall = (state == ST_WRITE_COMMIT);
  // code lock closes the programmer path but never the self-access path
  assign serial_programming_port_grant = serial_req && !lock_code;

  flash_array #(.ERASE_WRITE_CYC(ERASE_WRITE_CYC)) u_flash (
    .pclk    (pclk),
    .presetn (presetn),
    .req     (freq),
    .rd_data (flash_rd_data),
    .busy    (flash_busy),
    .done    (flash_done)
  );

  // ****************************************************************
  // sequencer registers and power-up timer
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state         <= ST_IDLE;
      seq_count     <= '0;
      powerup_count <= 21'(POWERUP_CYC);
      powerup_done  <= 1'b0;
    end else begin
      state     <= next_state;
      seq_count <= (state == next_state) ? seq_count + 2'd1 : 2'd0;
      if (powerup_count != '0) begin
        powerup_count <= powerup_count - 21'd1;
      end
      powerup_done <= (powerup_count == '0);
    end
  end

  // ****************************************************************
  // triggers and permit bit; software set beats hardware clear
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      program_permit_bit <= 1'b0;
      read_trigger       <= 1'b0;
      write_trigger      <= 1'b0;
    end else begin
      if (wr_control) begin
        program_permit_bit <= wbyte[BIT_PROGRAM_PERMIT];
      end
      // a written zero never clears a trigger
      if (start_read) begin
        read_trigger <= 1'b1;
      end else if (state == ST_READ_CAPTURE) begin
        read_trigger <= 1'b0;
      end
      if (start_write) begin
        write_trigger <= 1'b1;
      end else if (next_state == ST_IDLE && state != ST_IDLE) begin
        write_trigger <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // unlock key: 55h then AAh arms only the next register write, if it is a control write
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_stage <= 2'd0;
    end else if (wr_key) begin
      if (wbyte == KEY_FIRST) begin
        key_stage <= 2'd1;
      end else if (wbyte == KEY_SECOND && key_stage == 2'd1) begin
        key_stage <= 2'd2;
      end else begin
        key_stage <= 2'd0;
      end
    end else if (wr_access) begin
      // any other register write spends or breaks the sequence
      key_stage <= 2'd0;
    end
  end

  // ****************************************************************
  // data and address registers; a completing read wins over software
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_low  <= RESET_BYTE;
      word_high <= '0;
      addr_low  <= RESET_BYTE;
      addr_high <= '0;
    end else begin
      if (state == ST_READ_CAPTURE) begin
        word_low  <= flash_rd_data[7:0];
        word_high <= flash_rd_data[WORD_W-1:8];
      end else begin
        if (wr_wlow) begin
          word_low <= wbyte;
        end
        if (wr_whigh) begin
          word_high <= wbyte[WORD_HIGH_BITS-1:0];
        end
      end
      if (wr_alow) begin
        addr_low <= wbyte;
      end
      if (wr_ahigh) begin
        addr_high <= wbyte[ADDR_HIGH_BITS-1:0];
      end
    end
  end

  // ****************************************************************
  // read mux, captured during the setup phase so prdata is registered
  // ****************************************************************
  wire [7:0] control_view = CONTROL_FIXED_ONES
                            | {5'b0, program_permit_bit, write_trigger, read_trigger};
  logic [7:0] read_byte;
  always_comb begin
    case (word_index[7:0])
      IDX_ACCESS_CONTROL: read_byte = control_view;
      IDX_WORD_LOW:       read_byte = word_low;
      IDX_WORD_HIGH:      read_byte = {2'b00, word_high};
      IDX_ADDR_LOW:       read_byte = addr_low;
      IDX_ADDR_HIGH:      read_byte = {5'b0, addr_high};
      IDX_UNLOCK_KEY:     read_byte = 8'h00;
      default:            read_byte = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      prdata  <= (!pwrite && in_map) ? {24'h000000, read_byte} : 32'h0000_0000;
      pslverr <= !in_map; // unmapped addresses answer with an error
    end
  end

  // zero wait states: the answer is ready in the first access cycle
  assign pready = 1'b1;

endmodule : program_flash_self_access
`default_nettype wire

// >>> verification/flash_cfg_model.sv
// configuration pins and programmer request seen by the block
`timescale 1ns/100ps
`default_nettype none
module flash_cfg_model (
  input  wire logic       pclk,
  input  wire logic [3:0] mode,       // {code lock, programmer request, lock select}
  output logic      [1:0] lock_sel,   // block lock setting
  output logic            code_lock,  // high keeps the programmer out
  output logic            port_req    // programmer asks for access
);
  // pins move only at clock edges, like latched configuration fuses
  always_ff @(posedge pclk) begin
    lock_sel  <= mode[1:0];
    code_lock <= mode[3];
    port_req  <= mode[2];
  end
endmodule : flash_cfg_model
`default_nettype wire

// >>> verification/program_flash_self_access_properties.sv
// port-level checker for the program flash self-access block
`timescale 1ns/100ps
`default_nettype none
module program_flash_self_checker
  import flash_self_pkg::*;
#(
  parameter int ERASE_WRITE_CYC = 10  // erase/program length in cycles
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        code_lock,
  input wire logic        serial_programming_port_req,
  input wire logic        serial_programming_port_grant,
  input wire logic        suppress_instruction,
  input wire logic        core_stall
);
  // ****************************************************************
  // decode helpers
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic rd_setup = psel && !penable && !pwrite;  // read setup cycle
  wire logic ctl_hit = paddr == {2'b00, IDX_ACCESS_CONTROL, 2'b00};
  wire logic rd_start = psel && penable && pwrite && pstrb[0] && pwdata[0] && ctl_hit;
  int stall_cnt;  // length of the current stall
  // counter keeps the long stall check off a huge repetition
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) stall_cnt <= 0;
    else stall_cnt <= core_stall ? stall_cnt + 1 : 0;
  end
  // ****************************************************************
  // assertions
  // ****************************************************************
  a_ctl_fixed: assert property (rd_setup && ctl_hit |=> prdata[7:3] == 5'b10000)
    else $error("control fixed bits wrong");
  a_key_zero: assert property (rd_setup && paddr == {2'b00, IDX_UNLOCK_KEY, 2'b00} |=> prdata == 32'h0)
    else $error("key port read not zero");
  a_word_high: assert property (rd_setup && paddr == {2'b00, IDX_WORD_HIGH, 2'b00} |=> prdata[7:6] == 2'b00)
    else $error("word high top bits set");
  a_addr_high: assert property (rd_setup && paddr == {2'b00, IDX_ADDR_HIGH, 2'b00} |=> prdata[7:3] == 5'h00)
    else $error("address high top bits set");
  a_read_slot: assert property (rd_start |=> !suppress_instruction ##1 suppress_instruction ##1 !suppress_instruction)
    else $error("read slot timing wrong");
  a_lock_grant: assert property (code_lock [*8] |-> !serial_programming_port_grant)
    else $error("programmer granted while locked");
  a_open_grant: assert property ((serial_programming_port_req && !code_lock) [*8] |-> serial_programming_port_grant)
    else $error("programmer not granted");
  a_stall_min: assert property ($fell(core_stall) |-> $past(stall_cnt) >= ERASE_WRITE_CYC)
    else $error("erase/program stall too short");
  a_stall_max: assert property (stall_cnt <= ERASE_WRITE_CYC + 8)
    else $error("erase/program stall too long");
endmodule : program_flash_self_checker
bind program_flash_self_access program_flash_self_checker #(.ERASE_WRITE_CYC(ERASE_WRITE_CYC))
  program_flash_self_checker_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
  .code_lock, .serial_programming_port_req, .serial_programming_port_grant, .suppress_instruction, .core_stall);
`default_nettype wire

// >>> verification/test_program_flash_self_access.sv
// self-checking bench for the program flash self-access block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin n_errors++; \
  $display("ERROR %s exp %h got %h", n, (e), (a)); end end
module test_program_flash_self_access;
  import flash_self_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, grant, sup, stall;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;  // rd: last read data
  logic [3:0]  mode;                // partner pin settings
  logic [1:0]  lock_sel;
  logic        code_lock, port_req;
  int          n_errors, checks_done;
  logic        ack;                 // write trigger seen set just after a start
  program_flash_self_access #(.POWERUP_CYC(60), .ERASE_WRITE_CYC(10)) program_flash_self_access_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF), .pready, .prdata, .pslverr,
    .block_lock_select(lock_sel), .code_lock, .serial_programming_port_req(port_req),
    .serial_programming_port_grant(grant), .suppress_instruction(sup), .core_stall(stall));
  flash_cfg_model flash_cfg_model_inst (.pclk, .mode, .lock_sel, .code_lock, .port_req);
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // one apb transfer; the idle edge at the end keeps psel from toggling twice
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // poll control until the masked trigger bits clear
  task automatic idle(input logic [7:0] m);
    rd = {24'h0, m};
    while ((rd[7:0] & m) !== 8'h00) apb(0, IDX_ACCESS_CONTROL, 8'h00);
  endtask : idle
  task automatic put(input logic [10:0] a, input logic [13:0] v);
    apb(1, IDX_ADDR_LOW, a[7:0]);
    apb(1, IDX_ADDR_HIGH, {5'b00000, a[10:8]});
    apb(1, IDX_WORD_LOW, v[7:0]);
    apb(1, IDX_WORD_HIGH, {2'b00, v[13:8]});
    apb(1, IDX_ACCESS_CONTROL, 8'h04);
    apb(1, IDX_UNLOCK_KEY, KEY_FIRST);
    apb(1, IDX_UNLOCK_KEY, KEY_SECOND);
    apb(1, IDX_ACCESS_CONTROL, 8'h06);
    // the idle poll always ends at zero, so acceptance is caught on the first read
    apb(0, IDX_ACCESS_CONTROL, 8'h00);
    ack = rd[1];
    idle(8'h02);
  endtask : put
  task automatic get(input logic [10:0] a, output logic [13:0] v);
    apb(1, IDX_ADDR_LOW, a[7:0]);
    apb(1, IDX_ADDR_HIGH, {5'b00000, a[10:8]});
    apb(1, IDX_ACCESS_CONTROL, 8'h01);
    idle(8'h01);
    apb(0, IDX_WORD_LOW, 8'h00);
    v[7:0] = rd[7:0];
    apb(0, IDX_WORD_HIGH, 8'h00);
    v[13:8] = rd[5:0];
  endtask : get
  task automatic t_regs;
    apb(0, IDX_ACCESS_CONTROL, 8'h00);
    `CHK("control reset", 32'h80, rd)
    apb(0, 8'h92, 8'h00);
    `CHK("unmapped", 1'b1, pslverr)
    put(11'h011, 14'h0000);
    `CHK("early write", 1'b0, ack)
    `CHK("early permit", 32'h84, rd)
    apb(0, IDX_UNLOCK_KEY, 8'h00);
    `CHK("key", 32'h0, rd)
    apb(1, IDX_WORD_HIGH, 8'hFF);
    apb(0, IDX_WORD_HIGH, 8'h00);
    `CHK("word_high", 32'h3F, rd)
    apb(1, IDX_ADDR_HIGH, 8'hFF);
    apb(0, IDX_ADDR_HIGH, 8'h00);
    `CHK("addr_high", 32'h07, rd)
    repeat (70) @(posedge pclk);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_block;
    logic [13:0] v;
    for (int i = 0; i < 4; i++) begin
      put(11'(11'h010 + i), 14'(14'h1230 + i));
      `CHK("accepted", 1'b1, ack)
    end
    for (int i = 0; i < 5; i++) begin
      get(11'(11'h010 + i), v);
      `CHK("word", (i < 4) ? 14'h1230 + i : ERASED_WORD, v)
    end
    $display("t_block done");
  endtask : t_block
  task automatic t_refuse;
    logic [13:0] v;
    apb(1, IDX_ADDR_LOW, 8'h13);
    apb(1, IDX_ACCESS_CONTROL, 8'h04);
    apb(1, IDX_ACCESS_CONTROL, 8'h06);
    apb(0, IDX_ACCESS_CONTROL, 8'h00);
    `CHK("unkeyed", 32'h84, rd)
    apb(1, IDX_ACCESS_CONTROL, 8'h00);
    apb(1, IDX_UNLOCK_KEY, KEY_FIRST);
    apb(1, IDX_UNLOCK_KEY, KEY_SECOND);
    apb(1, IDX_ACCESS_CONTROL, 8'h06);
    apb(0, IDX_ACCESS_CONTROL, 8'h00);
    `CHK("unpermitted", 32'h84, rd)
    mode <= 4'b0010;
    repeat (8) @(posedge pclk);
    put(11'h013, 14'h0000);
    `CHK("locked start", 1'b0, ack)
    get(11'h013, v);
    `CHK("locked", 14'h1233, v)
    $display("t_refuse done");
  endtask : t_refuse
  task automatic t_port;
    logic [13:0] v;
    mode <= 4'b1111;
    repeat (8) @(posedge pclk);
    @(negedge pclk);
    `CHK("grant locked", 1'b0, grant)
    @(posedge pclk);
    get(11'h010, v);
    `CHK("locked read", 14'h1230, v)
    mode <= 4'b0111;
    repeat (8) @(posedge pclk);
    @(negedge pclk);
    `CHK("grant open", 1'b1, grant)
    $display("t_port done");
  endtask : t_port
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  // watchdog: the whole sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    end_of_test;
  end
  initial begin
    {psel, penable, pwrite} = 3'b000;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    mode    = 4'b0011;
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_block;
    t_refuse;
    t_port;
    end_of_test;
  end
endmodule : test_program_flash_self_access
`default_nettype wire
